// file: core/aom_audio_out.sv
// audio output mapper: register slave, config crossing, serial formatter and pin drivers
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aom_consts.svh"
// Behaviour
// - two-bit rotation moves each stream one pin further per step, wrapping
// - reverse bit flips the pin order produced by the rotation
// - rotation and reverse are independent; every combination is valid
// - five-bit width sets right-justified data bits per slot, reset 24
// - format field: I2S, right-justified, left-justified or raw AES3
// - format applies for sample packets, or high-bit-rate with manual override and output select 0
// - linear PCM: one stereo pair per pin in the selected I2S-family format
// - format 3 puts an AES3 stream on each of audio pins 1..4
// - compressed audio with mute mask 0 goes out as a binary stream
// - compressed sample packets can go out as an IEC61937 stream
// - streams 0..3 carry channels 1-2 .. 7-8; dedicated SPDIF output too
// - drive bit clock, left/right clock and master clock with the data
// - one-bit audio uses six channels with bit and master clocks
// - audio pin 0 carries the dedicated SPDIF stream in every mode except one-bit audio, where it carries one-bit channel 0
// - rotation and reverse also place the high-bit-rate block outputs
module aom_audio_out
    import aom_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`AOM_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AOM_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [1:0] audio_packet_kind,
    input wire logic compressed_audio,
    input wire logic link_clk,
    input wire logic [3:0][`AOM_SAMPLE_MSB:0] pcm_left,
    input wire logic [3:0][`AOM_SAMPLE_MSB:0] pcm_right,
    input wire logic [3:0] aes3_in,
    input wire logic dedicated_spdif_in,
    input wire logic [5:0] one_bit_in,
    output logic audio_pin_0,
    output logic audio_pin_1,
    output logic audio_pin_2,
    output logic audio_pin_3,
    output logic audio_pin_4,
    output logic lr_clock_out,
    output logic bit_clock_out,
    output logic master_clock_out
);
    localparam aom_cfg_t cfg_reset = '{rot: `AOM_RST_ROT, rev: `AOM_RST_REV, width: `AOM_RST_WIDTH,
        fmt: aom_fmt_i2s, ovr: `AOM_RST_SRC, hsel: `AOM_RST_SRC, mute: `AOM_RST_SRC,
        kind: aom_kind_none, compressed: `AOM_RST_SRC};

    //------------------------------------------------------------
    // register bus slave
    //------------------------------------------------------------
    logic [9:0] aw_idx;
    logic [31:0] w_data;
    logic w_lane0;
    logic [4:0] rj_word_width;
    aom_fmt_t serial_format_select;
    logic [1:0] stream_pin_rotation;
    logic stream_pin_reverse;
    logic hbr_manual_override;
    logic hbr_output_select;
    logic compressed_audio_mute_mask;
    logic cfg_busy;

    // decode of the held write and the incoming read
    wire wr_fire = !awready && !wready && !bvalid;
    wire wr_fmt = aw_idx == `AOM_IDX_FMT;
    wire wr_map = aw_idx == `AOM_IDX_MAP;
    wire wr_src = aw_idx == `AOM_IDX_SRC;
    wire wr_known = wr_fmt || wr_map || wr_src || (aw_idx == `AOM_IDX_STAT);
    wire [9:0] ar_idx = araddr[`AOM_ADDR_W-1:2];
    wire rd_fmt = ar_idx == `AOM_IDX_FMT;
    wire rd_map = ar_idx == `AOM_IDX_MAP;
    wire rd_src = ar_idx == `AOM_IDX_SRC;
    wire rd_stat = ar_idx == `AOM_IDX_STAT;
    wire rd_known = rd_fmt || rd_map || rd_src || rd_stat;
    wire [31:0] rd_word =
        rd_fmt ? {25'h0, serial_format_select, rj_word_width} :
        rd_map ? {25'h0, stream_pin_reverse, stream_pin_rotation, 4'h0} :
        rd_src ? {29'h0, compressed_audio_mute_mask, hbr_output_select, hbr_manual_override} :
        rd_stat ? {31'h0, cfg_busy} : 32'h0;

    // address and data are taken in either order, the write fires once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_idx <= 10'h0;
            w_data <= 32'h0;
            w_lane0 <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_idx <= awaddr[`AOM_ADDR_W-1:2];
            end else if (wr_fire) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_lane0 <= wstrb[0];
            end else if (wr_fire) begin
                wready <= 1'b1;
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `AOM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `AOM_RESP_OKAY : `AOM_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // control fields; every field sits in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rj_word_width <= `AOM_RST_WIDTH;
            serial_format_select <= aom_fmt_i2s;
            stream_pin_rotation <= `AOM_RST_ROT;
            stream_pin_reverse <= `AOM_RST_REV;
            hbr_manual_override <= `AOM_RST_SRC;
            hbr_output_select <= `AOM_RST_SRC;
            compressed_audio_mute_mask <= `AOM_RST_SRC;
        end else if (wr_fire && w_lane0) begin
            if (wr_fmt) begin
                rj_word_width <= w_data[`AOM_WIDTH_MSB:`AOM_WIDTH_LSB];
                serial_format_select <= aom_fmt_t'(w_data[`AOM_FMT_MSB:`AOM_FMT_LSB]);
            end
            if (wr_map) begin
                stream_pin_rotation <= w_data[`AOM_ROT_MSB:`AOM_ROT_LSB];
                stream_pin_reverse <= w_data[`AOM_REV_BIT];
            end
            if (wr_src) begin
                hbr_manual_override <= w_data[`AOM_OVR_BIT];
                hbr_output_select <= w_data[`AOM_HSEL_BIT];
                compressed_audio_mute_mask <= w_data[`AOM_MUTE_BIT];
            end
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `AOM_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_known ? `AOM_RESP_OKAY : `AOM_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // configuration crossing into the link domain
    //------------------------------------------------------------
    aom_cfg_t cfg_now;
    aom_cfg_t cfg_xfer;
    logic cfg_req;
    logic cfg_ack;
    logic ack_s1;
    logic ack_s2;

    // packet kind and compressed flag come from logic on aclk, no synchroniser
    assign cfg_now = '{rot: stream_pin_rotation, rev: stream_pin_reverse, width: rj_word_width,
        fmt: serial_format_select, ovr: hbr_manual_override, hsel: hbr_output_select,
        mute: compressed_audio_mute_mask, kind: aom_kind_t'(audio_packet_kind),
        compressed: compressed_audio};
    assign cfg_busy = cfg_req != ack_s2;
    wire cfg_send = !cfg_busy && (cfg_now != cfg_xfer);

    // toggle handshake; the word is held still until the far side acknowledges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_req <= 1'b0;
            cfg_xfer <= cfg_reset;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= cfg_ack;
            ack_s2 <= ack_s1;
            if (cfg_send) begin
                cfg_xfer <= cfg_now;
                cfg_req <= ~cfg_req;
            end
        end
    end

    //------------------------------------------------------------
    // link domain: reset, frame timing and settings in force
    //------------------------------------------------------------
    logic lrst_s1;
    logic lrst_n;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    aom_cfg_t cfg_pend;
    logic pend_valid;
    aom_cfg_t live;
    logic [1:0] phase;
    logic [5:0] bit_idx;

    // reset release is carried into the link clock before anything there uses it
    always_ff @(posedge link_clk) begin
        lrst_s1 <= aresetn;
        lrst_n <= lrst_s1;
    end

    wire [1:0] next_phase = phase + 2'h1;
    wire adv = phase == `AOM_PHASE_ADV;
    wire [5:0] nb = bit_idx + 6'h1;
    wire frame_turn = adv && (bit_idx == `AOM_TURN_BIT);
    wire req_edge = req_s2 != req_s3;

    // bit clock falls as the bit index advances; master clock is half the link clock
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            phase <= 2'h0;
            bit_idx <= 6'h0;
            bit_clock_out <= 1'b0;
            master_clock_out <= 1'b0;
        end else begin
            phase <= next_phase;
            bit_clock_out <= next_phase[1];
            master_clock_out <= ~master_clock_out;
            if (adv) begin
                bit_idx <= nb;
            end
        end
    end

    // new settings wait in a holding word and go live between frames only
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            cfg_ack <= 1'b0;
            cfg_pend <= cfg_reset;
            pend_valid <= 1'b0;
            live <= cfg_reset;
        end else begin
            req_s1 <= cfg_req;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_edge) begin
                cfg_pend <= cfg_xfer;
                cfg_ack <= req_s2;
            end
            pend_valid <= req_edge || (pend_valid && !frame_turn); // arrival beats the clear
            if (frame_turn && pend_valid) begin
                live <= cfg_pend;
            end
        end
    end

    //------------------------------------------------------------
    // serial formatting per stream
    //------------------------------------------------------------
    // one bit of a 32-bit slot; k counts from the slot start, rj counts back from its end
    function automatic logic slot_bit(input logic [`AOM_SAMPLE_MSB:0] s, input logic [4:0] k,
                                      input aom_fmt_t f, input logic [4:0] w);
        logic [4:0] m;
        logic b;
        m = `AOM_SLOT_LAST - k;
        b = 1'b0;
        case (f)
            aom_fmt_i2s: b = (k != 5'h0 && k <= `AOM_SAMPLE_W) ? s[`AOM_SAMPLE_W - k] : 1'b0;
            aom_fmt_lj: b = (k < `AOM_SAMPLE_W) ? s[`AOM_SAMPLE_MSB - k] : 1'b0;
            aom_fmt_rj: b = (m < w) ? ((m < `AOM_SAMPLE_W) ? s[m] : s[`AOM_SAMPLE_MSB]) : 1'b0;
            default: b = 1'b0;
        endcase
        return b;
    endfunction

    // high-bit-rate without manual choice, or with the raw choice, always leaves as AES3
    wire hbr_raw = (live.kind == aom_kind_hbr) && (!live.ovr || live.hsel);
    wire [1:0] fmt_eff_bits = hbr_raw ? aom_fmt_aes3 : live.fmt;
    wire aom_fmt_t fmt_eff = aom_fmt_t'(fmt_eff_bits);
    wire one_bit_mode = live.kind == aom_kind_one_bit;
    wire aes_mode = (fmt_eff == aom_fmt_aes3) && !one_bit_mode;
    // compressed payload is blanked only when the mask asks for it
    wire mute_now = live.compressed && live.mute;
    wire next_lr = (fmt_eff == aom_fmt_i2s) ? nb[5] : ~nb[5];
    wire [3:0] pcm_bit;

    aom_route_if rt();

    // each stream keeps its own stereo pair, latched one bit before the frame turns
    for (genvar i = 0; i < 4; i++) begin : g_stream
        logic [`AOM_SAMPLE_MSB:0] smp_l;
        logic [`AOM_SAMPLE_MSB:0] smp_r;
        always_ff @(posedge link_clk) begin
            if (!lrst_n) begin
                smp_l <= '0;
                smp_r <= '0;
            end else if (frame_turn) begin
                smp_l <= pcm_left[i];
                smp_r <= pcm_right[i];
            end
        end
        assign pcm_bit[i] = slot_bit(nb[5] ? smp_r : smp_l, nb[4:0], fmt_eff, live.width)
            && !mute_now;
    end

    // the same router places pcm, compressed and high-bit-rate streams
    assign rt.stream_bit = aes_mode ? aes3_in : pcm_bit;
    assign rt.rot = live.rot;
    assign rt.rev = live.rev;

    aom_pin_router u_router (
        .rt(rt)
    );

    //------------------------------------------------------------
    // pin drivers
    //------------------------------------------------------------
    // raw streams move every link cycle; framed data and one-bit audio move on bit edges
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            audio_pin_0 <= 1'b0;
            audio_pin_1 <= 1'b0;
            audio_pin_2 <= 1'b0;
            audio_pin_3 <= 1'b0;
            audio_pin_4 <= 1'b0;
            lr_clock_out <= 1'b0;
        end else if (one_bit_mode) begin
            if (adv) begin
                audio_pin_0 <= one_bit_in[0];
                audio_pin_1 <= one_bit_in[1];
                audio_pin_2 <= one_bit_in[2];
                audio_pin_3 <= one_bit_in[3];
                audio_pin_4 <= one_bit_in[4];
                lr_clock_out <= one_bit_in[5];
            end
        end else begin
            audio_pin_0 <= dedicated_spdif_in;
            if (adv) begin
                lr_clock_out <= next_lr;
            end
            if (adv || aes_mode) begin
                audio_pin_1 <= rt.pin_bit[0];
                audio_pin_2 <= rt.pin_bit[1];
                audio_pin_3 <= rt.pin_bit[2];
                audio_pin_4 <= rt.pin_bit[3];
            end
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_bclk_high;
        bit_clock_out [*2];
    endsequence

    sequence s_bclk_period;
        !bit_clock_out ##1 s_bclk_high ##1 !bit_clock_out;
    endsequence

    chk_pin0_spdif: assert property (@(posedge link_clk) disable iff (!lrst_n)
        !one_bit_mode |=> audio_pin_0 == $past(dedicated_spdif_in))
        else $error("pin 0 lost the dedicated spdif stream");

    chk_rot_step: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (aes_mode && !live.rev && live.rot == 2'h1) |=>
        (audio_pin_1 == $past(aes3_in[3])) && (audio_pin_2 == $past(aes3_in[0])))
        else $error("rotation one misplaced streams");

    chk_rev_order: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (aes_mode && live.rev && live.rot == 2'h0) |=>
        (audio_pin_1 == $past(aes3_in[3])) && (audio_pin_4 == $past(aes3_in[0])))
        else $error("reversal did not flip pin order");

    chk_rev_rot_mix: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (aes_mode && live.rev && live.rot == 2'h1) |=>
        (audio_pin_1 == $past(aes3_in[2])) && (audio_pin_4 == $past(aes3_in[3])))
        else $error("rotation with reversal misplaced streams");

    chk_cfg_frame: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (live != $past(live)) |-> $past(frame_turn))
        else $error("settings changed inside a frame");

    chk_hbr_auto: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (live.kind == aom_kind_hbr && !live.ovr) |-> fmt_eff == aom_fmt_aes3)
        else $error("automatic high-bit-rate output not raw");

    chk_i2s_lr: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (adv && !one_bit_mode && fmt_eff == aom_fmt_i2s) |=> lr_clock_out == bit_idx[5])
        else $error("i2s frame clock out of step");

    chk_rj_pad: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (adv && !one_bit_mode && fmt_eff == aom_fmt_rj && !live.rev && live.rot == 2'h0 &&
         (`AOM_SLOT_LAST - nb[4:0]) >= live.width) |=> !audio_pin_1)
        else $error("right-justified pad bit not zero");

    chk_mute_comp: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (adv && !aes_mode && !one_bit_mode && mute_now) |=>
        {audio_pin_1, audio_pin_2, audio_pin_3, audio_pin_4} == 4'h0)
        else $error("masked compressed audio not silenced");

    chk_one_bit: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (one_bit_mode && adv) |=> (audio_pin_0 == $past(one_bit_in[0])) && (lr_clock_out == $past(one_bit_in[5])))
        else $error("one-bit channel not on its pin");

    chk_bclk_shape: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(bit_clock_out) |-> !master_clock_out ##1 s_bclk_period)
        else $error("bit clock not four link cycles");
endmodule
`default_nettype wire

// file: core/aom_consts.svh
// register offsets, field positions, reset values and counts of the audio output mapper
`ifndef AOM_CONSTS_SVH
`define AOM_CONSTS_SVH
// register indices; byte address is four times the index
`define AOM_IDX_FMT 10'h003
`define AOM_IDX_MAP 10'h06d
`define AOM_IDX_SRC 10'h070
`define AOM_IDX_STAT 10'h071
`define AOM_ADDR_W 12
// field positions
`define AOM_WIDTH_LSB 0
`define AOM_WIDTH_MSB 4
`define AOM_FMT_LSB 5
`define AOM_FMT_MSB 6
`define AOM_ROT_LSB 4
`define AOM_ROT_MSB 5
`define AOM_REV_BIT 6
`define AOM_OVR_BIT 0
`define AOM_HSEL_BIT 1
`define AOM_MUTE_BIT 2
// reset values
`define AOM_RST_WIDTH 5'h18
`define AOM_RST_ROT 2'h0
`define AOM_RST_REV 1'h0
`define AOM_RST_SRC 1'h0
// slot geometry
`define AOM_SAMPLE_MSB 23
`define AOM_SAMPLE_W 5'h18
`define AOM_SLOT_LAST 5'h1f
`define AOM_TURN_BIT 6'h3e
`define AOM_PHASE_ADV 2'h3
// bus answers
`define AOM_RESP_OKAY 2'h0
`define AOM_RESP_SLVERR 2'h2
`endif

// file: core/aom_pin_router.sv
// rotation and reversal of four serial streams onto audio pins 1..4
`timescale 1ns/1ps
`default_nettype none
module aom_pin_router
    import aom_pkg::*;
(
    aom_route_if.router rt
);
    // pin j takes stream (j - rot), or (3 - j - rot) when reversed; both wrap mod 4
    for (genvar j = 0; j < 4; j++) begin : g_pin
        wire [1:0] fwd_src;
        wire [1:0] rev_src;
        assign fwd_src = 2'(j) - rt.rot;
        assign rev_src = 2'(3 - j) - rt.rot;
        assign rt.pin_bit[j] = rt.rev ? rt.stream_bit[rev_src] : rt.stream_bit[fwd_src];
    end
endmodule
`default_nettype wire

// file: core/aom_pkg.sv
// types shared by the audio output mapper modules
package aom_pkg;
    typedef enum logic [1:0] {
        aom_fmt_i2s = 2'b00,
        aom_fmt_rj = 2'b01,
        aom_fmt_lj = 2'b10,
        aom_fmt_aes3 = 2'b11
    } aom_fmt_t;
    typedef enum logic [1:0] {
        aom_kind_none = 2'b00,
        aom_kind_sample = 2'b01,
        aom_kind_hbr = 2'b10,
        aom_kind_one_bit = 2'b11
    } aom_kind_t;
    typedef struct packed {
        logic [1:0] rot;
        logic rev;
        logic [4:0] width;
        aom_fmt_t fmt;
        logic ovr;
        logic hsel;
        logic mute;
        aom_kind_t kind;
        logic compressed;
    } aom_cfg_t;
endpackage

// file: core/aom_route_if.sv
// stream-to-pin routing signals between the output core and the router
`timescale 1ns/1ps
`default_nettype none
interface aom_route_if;
    logic [3:0] stream_bit;
    logic [1:0] rot;
    logic rev;
    logic [3:0] pin_bit;
    modport src (output stream_bit, output rot, output rev, input pin_bit);
    modport router (input stream_bit, input rot, input rev, output pin_bit);
endinterface
`default_nettype wire

// file: dv/aom_dac_model.sv
// receiving converter model: gathers 64-bit frames from audio pins 1..4
`timescale 1ns/1ps
`default_nettype none
module aom_dac_model (
    input wire logic bit_clock_out,
    input wire logic lr_clock_out,
    input wire logic [3:0] pins,
    input wire logic left_level,
    output logic [3:0][63:0] frame,
    output logic frame_tick
);
    logic [3:0][63:0] sh;
    logic lr_q = 1'b0;
    logic tick = 1'b0;
    assign frame_tick = tick;
    // sample mid-bit; a frame closes where lr turns to the left level
    always @(posedge bit_clock_out) begin
        lr_q <= lr_clock_out;
        if (lr_clock_out == left_level && lr_q != left_level) begin
            frame <= sh;
            tick <= ~tick;
        end
        for (int i = 0; i < 4; i++) begin
            sh[i] <= {sh[i][62:0], pins[i]};
        end
    end
endmodule
`default_nettype wire

// file: dv/aom_tb.sv
// self-checking bench of the audio output mapper
`timescale 1ns/1ps
`default_nettype none
`include "aom_consts.svh"
module testbench;
    logic aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0, lvl = 1'b0, comp = 1'b0, spdif = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, lr, bclk, tick;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [1:0] bresp, rresp, kind = 2'h1;
    logic [31:0] wdata = '0, rdata;
    logic [3:0][23:0] pl = '0, pr = '0;
    logic [3:0] aes = '0;
    logic [5:0] ob = '0;
    logic [4:0] pin;
    logic [3:0][63:0] frame;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [63:0] fq[$];
    int fail_count = 0, cmp_count = 0, cyc = 0;
    always #5 aclk = ~aclk;
    // offset start keeps link edges off the aclk edges
    always begin
        #1;
        link_clk = ~link_clk;
        #14;
    end
    aom_audio_out u_aom_audio_out (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .audio_packet_kind(kind), .compressed_audio(comp), .link_clk(link_clk), .pcm_left(pl),
        .pcm_right(pr), .aes3_in(aes), .dedicated_spdif_in(spdif), .one_bit_in(ob), .audio_pin_0(pin[0]),
        .audio_pin_1(pin[1]), .audio_pin_2(pin[2]), .audio_pin_3(pin[3]), .audio_pin_4(pin[4]),
        .lr_clock_out(lr), .bit_clock_out(bclk), .master_clock_out());
    aom_dac_model u_aom_dac_model (.bit_clock_out(bclk), .lr_clock_out(lr), .pins(pin[4:1]),
        .left_level(lvl), .frame(frame), .frame_tick(tick));
    //----------------------------------------
    // checking and bus helpers
    //----------------------------------------
    task automatic rep(input logic bad, input string m);
        cmp_count++;
        if (bad) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
        rep(g !== e, $sformatf("bus %h/%h", g, e));
    endtask
    task automatic cmp_frm(input logic [63:0] g, input logic [63:0] e);
        rep(g !== e, $sformatf("frame %h/%h", g, e));
    endtask
    task automatic cmp_pin(input logic [4:0] g, input logic [4:0] e);
        rep(g !== e, $sformatf("pins %b/%b", g, e));
    endtask
    // each channel released at the edge its ready is seen
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
        bq.push_back(er);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [33:0] e);
        rq.push_back(e);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    function automatic logic [1:0] src_of(input logic [1:0] j, input logic [1:0] rt, input logic rv);
        return rv ? 2'(2'h3 - j - rt) : 2'(j - rt);
    endfunction
    function automatic logic [31:0] slot(input logic [1:0] f, input logic [4:0] w, input logic [23:0] s);
        case (f)
            2'h0: return {1'b0, s, 7'h0};
            2'h2: return {s, 8'h0};
            default: return 32'(signed'(s)) & ((32'h1 << w) - 32'h1);
        endcase
    endfunction
    task automatic setup(input logic [1:0] k, input logic [2:0] src, input logic [1:0] f, input logic [4:0] w,
        input logic [1:0] rt, input logic rv);
        for (int i = 0; i < 4; i++) begin
            pl[i] <= 24'($urandom);
            pr[i] <= 24'($urandom);
        end
        kind <= k;
        lvl <= (f != 2'h0);
        wr(`AOM_IDX_SRC, {29'h0, src}, 2'h0);
        wr(`AOM_IDX_FMT, {25'h0, f, w}, 2'h0);
        wr(`AOM_IDX_MAP, {25'h0, rv, rt, 4'h0}, 2'h0);
    endtask
    // old frames may still be in flight, so skip a few before noting
    task automatic cf(input logic [1:0] k, input logic [2:0] src, input logic [1:0] f, input logic [4:0] w,
        input logic [1:0] rt, input logic rv);
        logic [1:0] s;
        setup(k, src, f, w, rt, rv);
        repeat (4) @(tick);
        for (int j = 0; j < 4; j++) begin
            s = src_of(2'(j), rt, rv);
            fq.push_back((comp && src[2]) ? 64'h0 : {slot(f, w, pl[s]), slot(f, w, pr[s])});
        end
        while (fq.size() != 0) @(posedge aclk);
    endtask
    task automatic raw(input logic [1:0] rt, input logic rv);
        logic [3:0] e;
        repeat (1500) @(posedge aclk);
        repeat (4) begin
            aes <= 4'($urandom);
            spdif <= 1'($urandom);
            ob <= 6'($urandom);
            repeat (20) @(posedge aclk);
            for (int j = 0; j < 4; j++) e[j] = aes[src_of(2'(j), rt, rv)];
            cmp_pin(pin, (kind == 2'h3) ? ob[4:0] : {e, spdif});
            if (kind == 2'h3) cmp_pin({4'h0, lr}, {4'h0, ob[5]});
        end
    endtask
    // scoreboard: oldest note against each answer
    always @(posedge aclk) begin
        if (bvalid && bready) cmp_bus({bresp, 32'h0}, {bq.pop_front(), 32'h0});
        if (rvalid && rready) cmp_bus({rresp, rdata}, rq.pop_front());
    end
    always @(tick) begin
        for (int i = 0; i < 4 && fq.size() != 0; i++) cmp_frm(frame[i], fq.pop_front());
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(60));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`AOM_IDX_FMT, {2'h0, 32'h18});
        rd(`AOM_IDX_MAP, {2'h0, 32'h0});
        rd(10'h040, {2'h2, 32'h0});
        wr(10'h040, 32'h7f, 2'h2);
        for (int c = 0; c < 8; c++) begin
            cf(2'h1, 3'h0, 2'h2, 5'd24, 2'(c), c[2]);
        end
        rd(`AOM_IDX_MAP, {2'h0, 32'h70});
        cf(2'h1, 3'h0, 2'h0, 5'd24, 2'h0, 1'b0);
        cf(2'h1, 3'h0, 2'h1, 5'd16, 2'h0, 1'b0);
        rd(`AOM_IDX_FMT, {2'h0, 32'h30});
        comp <= 1'b1;
        cf(2'h1, 3'h0, 2'h2, 5'd24, 2'h1, 1'b0);
        cf(2'h1, 3'h4, 2'h2, 5'd24, 2'h1, 1'b0);
        comp <= 1'b0;
        cf(2'h2, 3'h1, 2'h2, 5'd24, 2'h3, 1'b1);
        setup(2'h2, 3'h0, 2'h2, 5'd24, 2'h1, 1'b1);
        raw(2'h1, 1'b1);
        setup(2'h1, 3'h0, 2'h3, 5'd24, 2'h1, 1'b0);
        raw(2'h1, 1'b0);
        setup(2'h1, 3'h0, 2'h3, 5'd24, 2'h0, 1'b1);
        raw(2'h0, 1'b1);
        setup(2'h3, 3'h0, 2'h2, 5'd24, 2'h0, 1'b0);
        raw(2'h0, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
